// ---- bench/smmc_mem_model.sv ----
`timescale 1ns/1ps
// Memory array side: counts writes that reach the array
module smmc_mem_model (
    input  logic       clk,          // System clock
    input  logic       rstn,         // Async reset, low
    input  logic       mem_ack,      // Cycle complete
    input  logic       mem_write_en, // Write reaches memory
    output logic [7:0] wr_count      // Writes stored
);
    // One stored write per completed cycle with mem_write_en high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_count <= 8'h00;
        end else if (mem_ack && mem_write_en) begin
            wr_count <= wr_count + 8'h01;
        end
    end
endmodule // smmc_mem_model

// ---- bench/smmc_top_asserts.sv ----
`timescale 1ns/1ps
// Watches the memory cycle outputs of the map control
module smmc_top_asserts (
    input logic        clk,              // System clock
    input logic        rstn,             // Async reset, low
    input logic        mem_req,          // Memory request
    input logic        mem_ack,          // Cycle complete
    input logic [1:0]  cyc_kind,         // Cycle type
    input logic [23:0] phys_addr,        // Physical address
    input logic        dram_strobe,      // Row/column strobes
    input logic        exp_cycle,        // Expansion cycle
    input logic        rom_read,         // ROM read cycle
    input logic        sram_cycle,       // Pseudo-SRAM cycle
    input logic [3:0]  sram_bank_select, // Upper SRAM bank
    input logic        dram_mode         // DRAM mode active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_ack_delay: assert property (
        mem_ack |-> $past(mem_req, 3))
        else $error("ack without request three cycles before");
    chk_ack_pulse: assert property (mem_ack |=> !mem_ack)
        else $error("ack longer than one cycle");
    chk_strobe_len: assert property ($rose(dram_strobe) |=>
        dram_strobe && mem_ack ##1 !dram_strobe)
        else $error("strobe length wrong");
    chk_bank_idle: assert property (!sram_cycle |->
        sram_bank_select == 4'hF)
        else $error("bank select not all ones");
    chk_sram_mode: assert property (sram_cycle |->
        !dram_mode && !dram_strobe)
        else $error("pseudo-SRAM cycle in DRAM mode");
    chk_rom_phys: assert property (rom_read |->
        phys_addr[23:17] == 7'h00 && cyc_kind == 2'h2)
        else $error("ROM address outside 128K");
    chk_exp_kind: assert property (exp_cycle |->
        cyc_kind == 2'h1 && !dram_strobe)
        else $error("expansion cycle with strobes");
    chk_dram_kind: assert property (dram_strobe |->
        cyc_kind == 2'h0 && dram_mode)
        else $error("strobe outside DRAM cycle");
endmodule // smmc_top_asserts

// ---- bench/test_smmc_top.sv ----
`timescale 1ns/1ps
// Checker beside the top module
bind smmc_top smmc_top_asserts u_chk (.clk, .rstn, .mem_req, .mem_ack,
    .cyc_kind, .phys_addr, .dram_strobe, .exp_cycle, .rom_read,
    .sram_cycle, .sram_bank_select, .dram_mode);
module test_smmc_top;
    logic clk = 0, rstn = 0, strap_present = 1, strap_dram = 1;
    logic io_wr = 0, io_rd = 0, mem_req = 0, mem_wr = 0, big = 0, ilv = 0;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0]  io_wdata = 8'h00, io_rdata, wr_count;
    logic [23:0] mem_addr = 24'h000000, phys_addr;
    logic [1:0]  cyc_kind, dram_bank;
    logic [3:0]  sram_bank_select;
    logic mem_ack, dram_strobe, exp_cycle, rom_read, sram_cycle;
    logic mem_write_en, dram_mode, page_hit;
    int bad_count = 0, total_checks = 0, cycles = 0;
    smmc_top u_dut (.clk, .rstn, .strap_present, .strap_dram,
        .part_is_1m(big), .interleave_en(ilv), .io_wr, .io_rd, .io_addr,
        .io_wdata, .io_rdata, .mem_req, .mem_addr, .mem_wr, .mem_ack,
        .cyc_kind, .phys_addr, .dram_strobe, .dram_bank, .page_hit,
        .exp_cycle, .rom_read, .sram_cycle, .mem_write_en,
        .sram_bank_select, .dram_mode);
    smmc_mem_model u_mem (.clk, .rstn, .mem_ack, .mem_write_en, .wr_count);
    // Clock and hang guard
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            give_verdict();
        end
    end
    task check(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        io_wr <= 1'b1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        io_rd <= 1'b1;
        io_addr <= a;
        @(posedge clk);
        io_rd <= 1'b0;
        #1 check({16'h0000, io_rdata}, {16'h0000, e});
    endtask
    task iwr(input logic [7:0] i, input logic [7:0] d);
        wr(16'h0022, i);
        wr(16'h0023, d);
    endtask
    task ird(input logic [7:0] i, input logic [7:0] e);
        wr(16'h0022, i);
        rd(16'h0023, e);
    endtask
    // Expected value is {bank select, cycle kind, write enable}
    task mem(input logic [23:0] a, input logic w, input logic [6:0] e);
        @(posedge clk);
        mem_req <= 1'b1;
        mem_addr <= a;
        mem_wr <= w;
        @(posedge clk);
        mem_req <= 1'b0;
        @(posedge clk);
        #1 check({17'h0, sram_bank_select, cyc_kind, mem_write_en},
                 {17'h0, e});
        @(posedge clk);
        #1 check({23'h0, mem_ack}, 24'h000001);
    endtask
    // DRAM read, then expected {page hit, bank}
    task pgc(input logic [23:0] a, input logic [2:0] e);
        mem(a, 1'b0, 7'h78);
        check({21'h0, page_hit, dram_bank}, {21'h0, e});
    endtask
    task rst(input logic p, input logic d);
        @(posedge clk);
        rstn <= 1'b0;
        strap_present <= p;
        strap_dram <= d;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst(1'b1, 1'b1);
        check({23'h0, dram_mode}, 24'h000001);
        rd(16'h0104, 8'h1F);
        ird(8'h18, 8'h00);
        ird(8'h19, 8'h00);
        iwr(8'h19, 8'hFF);
        ird(8'h19, 8'h77);
        iwr(8'h19, 8'h00);
        wr(16'h0104, 8'hFE);
        rd(16'h0104, 8'h1E);
        rd(16'h0050, 8'h00);
        $display("register test done");
        mem(24'h000100, 1'b0, 7'h7A);
        mem(24'h020100, 1'b1, 7'h79);
        mem(24'h0E0000, 1'b0, 7'h7A);
        mem(24'h0F0000, 1'b0, 7'h7C);
        check(phys_addr, 24'h010000);
        mem(24'hFE0000, 1'b0, 7'h7C);
        mem(24'hFF0000, 1'b0, 7'h7C);
        check(phys_addr, 24'h010000);
        iwr(8'h19, 8'h01);
        mem(24'h0F0000, 1'b1, 7'h79);
        mem(24'h0F0000, 1'b0, 7'h7C);
        iwr(8'h19, 8'h11);
        mem(24'h0F0000, 1'b1, 7'h78);
        mem(24'h0F0000, 1'b0, 7'h78);
        iwr(8'h18, 8'h08);
        mem(24'h0C0000, 1'b0, 7'h7A);
        mem(24'h0C0000, 1'b1, 7'h79);
        iwr(8'h18, 8'h88);
        mem(24'h0C0000, 1'b0, 7'h78);
        mem(24'h0C0000, 1'b1, 7'h78);
        mem(24'h0C4000, 1'b0, 7'h7A);
        check({16'h0, wr_count}, 24'h000003);
        $display("decode test done");
        rst(1'b1, 1'b0);
        check({23'h0, dram_mode}, 24'h000000);
        mem(24'h140000, 1'b0, 7'h0E);
        rst(1'b0, 1'b0);
        check({23'h0, dram_mode}, 24'h000001);
        $display("strap test done");
        // Page hit and bank checks, DRAM top, then remap of 100000 to 0A0000
        pgc(24'h000100, 3'h0);
        pgc(24'h0003FE, 3'h4);
        pgc(24'h000400, 3'h0);
        @(posedge clk) big <= 1'b1;
        pgc(24'h000400, 3'h0);
        pgc(24'h0007FE, 3'h4);
        @(posedge clk) {big, ilv} <= 2'b01;
        pgc(24'h000C00, 3'h1);
        pgc(24'h100800, 3'h2);
        mem(24'h7FF000, 1'b0, 7'h78);
        mem(24'h800000, 1'b0, 7'h7A);
        iwr(8'h1A, 8'h01);
        ird(8'h1A, 8'h01);
        mem(24'h100000, 1'b0, 7'h78);
        check(phys_addr, 24'h0A0000);
        mem(24'h160000, 1'b0, 7'h78);
        check(phys_addr, 24'h160000);
        $display("page test done");
        give_verdict();
    end
endmodule // test_smmc_top

// ---- rtl/smmc_decode.sv ----
`timescale 1ns/1ps
module smmc_decode (
    input  smmc_pkg::smmc_req_t  req,         // Access to decode
    input  wire logic [7:0]      shadow_c,    // C segment shadow bits
    input  wire logic [7:0]      shadow_def,  // D/E/F shadow bits
    input  wire logic [7:0]      base_en,     // Base block enables
    input  wire logic            remap_en,    // Remap above 1M
    input  wire logic            sram_mode,   // Pseudo-SRAM mode
    input  wire logic [23:0]     mem_top,     // End of installed DRAM
    output smmc_pkg::smmc_dec_t  dec          // Decode result
);
    // ------------------------------------------------------------
    // Region and segment selection
    // ------------------------------------------------------------
    wire logic [23:0] a        = req.addr;
    wire logic        in_base  = a < smmc_pkg::ADDR_BASE_TOP;
    wire logic        in_c     = a[23:16] == smmc_pkg::SEG_C;
    wire logic        in_d     = a[23:16] == smmc_pkg::SEG_D;
    wire logic        in_e     = a[23:16] == smmc_pkg::SEG_E;
    wire logic        in_f     = a[23:16] == smmc_pkg::SEG_F;
    wire logic        in_hirom = a >= smmc_pkg::ADDR_HIROM;
    wire logic        above_1m = a >= smmc_pkg::ADDR_1M;
    wire logic        in_remap = above_1m
                                 && (a < smmc_pkg::ADDR_REMAP_TOP);
    // Segment bits in descending segment order
    wire logic        c_en  = shadow_c[{1'b0, ~a[15:14]}];
    wire logic        c_wd  = shadow_c[{1'b1, ~a[15:14]}];
    wire logic        d_en  = shadow_def[{1'b0, ~a[17:16]}];
    wire logic        d_wd  = shadow_def[{1'b1, ~a[17:16]}];
    wire logic        sh_en = in_c ? c_en : d_en;
    wire logic        sh_wd = in_c ? c_wd : d_wd;
    wire logic        any_shadow = (|shadow_c[3:0]) | (|shadow_def[2:0]);
    wire logic [23:0] rom_phys = {7'h00, a[16:0]};
    wire logic [23:0] off_1m   = a - smmc_pkg::ADDR_1M;

    // ------------------------------------------------------------
    // Cycle selection
    // ------------------------------------------------------------
    always_comb begin
        dec           = '0;
        dec.cyc       = smmc_pkg::SMMC_CYC_EXP;
        dec.phys      = a;
        dec.sram_bank = smmc_pkg::SRAM_NONE;
        if (in_base) begin
            if (base_en[a[19:17]]) begin
                dec.cyc = smmc_pkg::SMMC_CYC_DRAM;
            end
        end else if (in_c || in_d) begin
            if (sh_en && sh_wd) begin
                dec.cyc     = smmc_pkg::SMMC_CYC_DRAM;
                dec.discard = req.wr;
            end else if (sh_en && req.wr) begin
                dec.cyc = smmc_pkg::SMMC_CYC_DRAM;
            end
        end else if (in_e || in_f) begin
            if (sh_en && sh_wd) begin
                dec.cyc     = smmc_pkg::SMMC_CYC_DRAM;
                dec.discard = req.wr;
            end else if (sh_en && req.wr) begin
                dec.cyc = smmc_pkg::SMMC_CYC_DRAM;
            end else if ((sh_en || in_f) && !req.wr) begin
                dec.cyc  = smmc_pkg::SMMC_CYC_ROM;
                dec.phys = rom_phys;
            end
        end else if (in_hirom) begin
            if (!req.wr) begin
                dec.cyc  = smmc_pkg::SMMC_CYC_ROM;
                dec.phys = rom_phys;
            end
        end else if (above_1m) begin
            if (remap_en && !any_shadow && in_remap) begin
                dec.cyc  = smmc_pkg::SMMC_CYC_DRAM;
                dec.phys = off_1m + smmc_pkg::ADDR_BASE_TOP;
            end else if (sram_mode) begin
                if (a < smmc_pkg::ADDR_SRAM_TOP) begin
                    dec.cyc       = smmc_pkg::SMMC_CYC_DRAM;
                    dec.sram_bank = off_1m[21:18];
                end
            end else if (a < mem_top) begin
                dec.cyc = smmc_pkg::SMMC_CYC_DRAM;
            end
        end
        if (sram_mode && dec.cyc == smmc_pkg::SMMC_CYC_DRAM) begin
            dec.cyc = smmc_pkg::SMMC_CYC_SRAM;
        end
    end

endmodule // smmc_decode

// ---- rtl/smmc_pkg.sv ----
package smmc_pkg;

    // ------------------------------------------------------------
    // Register ports and indices
    // ------------------------------------------------------------
    localparam logic [15:0] PORT_INDEX     = 16'h0022;
    localparam logic [15:0] PORT_DATA      = 16'h0023;
    localparam logic [15:0] PORT_BASE_EN   = 16'h0104;
    localparam logic [7:0]  IDX_SHADOW_C   = 8'h18;
    localparam logic [7:0]  IDX_SHADOW_DEF = 8'h19;
    localparam logic [7:0]  IDX_REMAP      = 8'h1A;

    // ------------------------------------------------------------
    // Reset values and field layouts
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SHADOW   = 8'h00;
    localparam logic [7:0] RST_BASE_EN  = 8'h1F;
    localparam logic [7:0] RST_REMAP    = 8'h00;
    localparam logic [7:0] RST_INDEX    = 8'h00;
    localparam logic [7:0] MASK_SHADOW  = 8'hFF;
    localparam logic [7:0] MASK_DEF     = 8'h77;
    localparam logic [7:0] MASK_BASE_EN = 8'h1F;
    localparam logic [7:0] MASK_REMAP   = 8'h01;
    localparam int         REMAP_EN_BIT = 0;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [23:0] ADDR_BASE_TOP = 24'h0A0000;
    localparam logic [7:0]  SEG_C         = 8'h0C;
    localparam logic [7:0]  SEG_D         = 8'h0D;
    localparam logic [7:0]  SEG_E         = 8'h0E;
    localparam logic [7:0]  SEG_F         = 8'h0F;
    localparam logic [23:0] ADDR_HIROM    = 24'hFE0000;
    localparam logic [23:0] ADDR_1M       = 24'h100000;
    localparam logic [23:0] ADDR_REMAP_TOP = 24'h160000;
    localparam logic [23:0] ADDR_SRAM_TOP = 24'h4C0000;
    localparam logic [23:0] MB_SIZE       = 24'h100000;

    // ------------------------------------------------------------
    // DRAM geometry
    // ------------------------------------------------------------
    localparam int PAGE_SH_256K = 10;
    localparam int PAGE_SH_1M   = 11;
    localparam int BANK_SH_256K = 19;
    localparam int BANK_SH_1M   = 21;
    localparam int SRAM_BANK_SH = 18;
    localparam logic [3:0] SRAM_NONE = 4'hF;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SMMC_CYC_DRAM = 2'h0,
        SMMC_CYC_EXP  = 2'h1,
        SMMC_CYC_ROM  = 2'h2,
        SMMC_CYC_SRAM = 2'h3
    } smmc_cyc_t;

    typedef enum logic [1:0] {
        SMMC_ST_IDLE = 2'b00,
        SMMC_ST_DEC  = 2'b01,
        SMMC_ST_RUN  = 2'b11,
        SMMC_ST_DONE = 2'b10
    } smmc_state_t;

    typedef struct packed {
        logic [23:0] addr;
        logic        wr;
    } smmc_req_t;

    typedef struct packed {
        smmc_cyc_t   cyc;
        logic        discard;
        logic [23:0] phys;
        logic [3:0]  sram_bank;
    } smmc_dec_t;

endpackage

// ---- rtl/smmc_top.sv ----
`timescale 1ns/1ps
module smmc_top #(
    parameter int MEM_MB = 8                  // Installed DRAM, MB
) (
    input  wire logic        clk,             // System clock
    input  wire logic        rstn,            // Async reset, low
    input  wire logic        strap_present,   // Memory strap fitted
    input  wire logic        strap_dram,      // Strap: high for DRAM
    input  wire logic        part_is_1m,      // DRAM uses 1M parts
    input  wire logic        interleave_en,   // Two-way interleave
    input  wire logic        io_wr,           // I/O write strobe
    input  wire logic        io_rd,           // I/O read strobe
    input  wire logic [15:0] io_addr,         // I/O port address
    input  wire logic [7:0]  io_wdata,        // I/O write data
    output logic      [7:0]  io_rdata,        // I/O read data
    input  wire logic        mem_req,         // Memory request
    input  wire logic [23:0] mem_addr,        // Memory address
    input  wire logic        mem_wr,          // Request is a write
    output logic             mem_ack,         // Cycle complete
    output logic      [1:0]  cyc_kind,        // Cycle type
    output logic      [23:0] phys_addr,       // Physical address
    output logic             dram_strobe,     // Row/column strobes
    output logic      [1:0]  dram_bank,       // DRAM bank
    output logic             page_hit,        // Open page hit
    output logic             exp_cycle,       // Expansion bus cycle
    output logic             rom_read,        // ROM read cycle
    output logic             sram_cycle,      // Pseudo-SRAM cycle
    output logic             mem_write_en,    // Write reaches memory
    output logic      [3:0]  sram_bank_select, // Upper SRAM bank
    output logic             dram_mode        // DRAM mode active
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (MEM_MB < 1 || MEM_MB > 8) begin : g_bad_size
        $error("MEM_MB must lie between 1 and 8");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [23:0] MEM_TOP = 24'(MEM_MB) * smmc_pkg::MB_SIZE;

    smmc_pkg::smmc_state_t st_ff;
    smmc_pkg::smmc_state_t nxt_st;
    smmc_pkg::smmc_req_t   req_ff;
    smmc_pkg::smmc_dec_t   dec;
    logic [7:0]  index_ff;
    logic [7:0]  shadow_c_ff;
    logic [7:0]  shadow_def_ff;
    logic [7:0]  base_en_ff;
    logic [7:0]  remap_ff;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic        strap_done_ff;
    logic        dram_mode_ff;
    logic [1:0]  cyc_ff;
    logic [23:0] phys_ff;
    logic        strobe_ff;
    logic [1:0]  bank_ff;
    logic        hit_ff;
    logic        exp_ff;
    logic        rom_ff;
    logic        sram_ff;
    logic        wen_ff;
    logic [3:0]  sbank_ff;
    logic [13:0] open_pg_ff [4];
    logic [3:0]  open_vld_ff;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Page number of a physical address
    function automatic logic [13:0] page_of(input logic [23:0] pa,
                                            input logic        big);
        logic [23:0] sh;
        sh = big ? (pa >> smmc_pkg::PAGE_SH_1M)
                 : (pa >> smmc_pkg::PAGE_SH_256K);
        return sh[13:0];
    endfunction

    // Bank of a physical address, with optional interleave
    function automatic logic [1:0] bank_of(input logic [23:0] pa,
                                           input logic        big,
                                           input logic        ilv);
        logic [23:0] lin;
        logic [23:0] pair;
        logic [13:0] pg;
        lin  = big ? (pa >> smmc_pkg::BANK_SH_1M)
                   : (pa >> smmc_pkg::BANK_SH_256K);
        pair = big ? (pa >> (smmc_pkg::BANK_SH_1M + 1))
                   : (pa >> (smmc_pkg::BANK_SH_256K + 1));
        pg   = page_of(pa, big);
        if (ilv) begin
            return {pair[0], pg[0]};
        end
        return lin[1:0];
    endfunction

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    wire logic hit_index = io_addr == smmc_pkg::PORT_INDEX;
    wire logic hit_data  = io_addr == smmc_pkg::PORT_DATA;
    wire logic hit_base  = io_addr == smmc_pkg::PORT_BASE_EN;
    wire logic sel_c     = hit_data
                           && index_ff == smmc_pkg::IDX_SHADOW_C;
    wire logic sel_def   = hit_data
                           && index_ff == smmc_pkg::IDX_SHADOW_DEF;
    wire logic sel_remap = hit_data
                           && index_ff == smmc_pkg::IDX_REMAP;
    wire logic wr_index  = io_wr && hit_index;
    wire logic wr_base   = io_wr && hit_base;
    wire logic wr_c      = io_wr && sel_c;
    wire logic wr_def    = io_wr && sel_def;
    wire logic wr_remap  = io_wr && sel_remap;

    // Read data selection, unmapped reads return zero
    always_comb begin
        if (hit_index) begin
            nxt_rdata = index_ff;
        end else if (hit_base) begin
            nxt_rdata = base_en_ff;
        end else if (sel_c) begin
            nxt_rdata = shadow_c_ff;
        end else if (sel_def) begin
            nxt_rdata = shadow_def_ff;
        end else if (sel_remap) begin
            nxt_rdata = remap_ff;
        end else begin
            nxt_rdata = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Index register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            index_ff <= smmc_pkg::RST_INDEX;
        end else if (wr_index) begin
            index_ff <= io_wdata;
        end
    end

    // Shadow control, cleared at reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shadow_c_ff   <= smmc_pkg::RST_SHADOW;
            shadow_def_ff <= smmc_pkg::RST_SHADOW;
        end else begin
            if (wr_c) begin
                shadow_c_ff <= io_wdata & smmc_pkg::MASK_SHADOW;
            end
            if (wr_def) begin
                shadow_def_ff <= io_wdata & smmc_pkg::MASK_DEF;
            end
        end
    end

    // Base block enables and remap control
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            base_en_ff <= smmc_pkg::RST_BASE_EN;
            remap_ff   <= smmc_pkg::RST_REMAP;
        end else begin
            if (wr_base) begin
                base_en_ff <= io_wdata & smmc_pkg::MASK_BASE_EN;
            end
            if (wr_remap) begin
                remap_ff <= io_wdata & smmc_pkg::MASK_REMAP;
            end
        end
    end

    // Registered read data, one cycle after the read strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 8'h00;
        end else if (io_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Memory type strap, caught after reset release
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_done_ff <= 1'b0;
            dram_mode_ff  <= 1'b1;
        end else if (!strap_done_ff) begin
            strap_done_ff <= 1'b1;
            dram_mode_ff  <= strap_present ? strap_dram : 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    smmc_decode u_decode (
        .req        (req_ff),
        .shadow_c   (shadow_c_ff),
        .shadow_def (shadow_def_ff),
        .base_en    (base_en_ff),
        .remap_en   (remap_ff[smmc_pkg::REMAP_EN_BIT]),
        .sram_mode  (!dram_mode_ff),
        .mem_top    (MEM_TOP),
        .dec        (dec)
    );

    wire logic [13:0] dec_pg   = page_of(dec.phys, part_is_1m);
    wire logic [1:0]  dec_bank = bank_of(dec.phys, part_is_1m,
                                         interleave_en);
    wire logic        dec_dram = dec.cyc == smmc_pkg::SMMC_CYC_DRAM;
    wire logic        dec_hit  = open_vld_ff[dec_bank]
                                 && open_pg_ff[dec_bank] == dec_pg;

    // ------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------
    always_comb begin
        case (st_ff)
            smmc_pkg::SMMC_ST_IDLE:
                nxt_st = mem_req ? smmc_pkg::SMMC_ST_DEC
                                 : smmc_pkg::SMMC_ST_IDLE;
            smmc_pkg::SMMC_ST_DEC:  nxt_st = smmc_pkg::SMMC_ST_RUN;
            smmc_pkg::SMMC_ST_RUN:  nxt_st = smmc_pkg::SMMC_ST_DONE;
            default:                nxt_st = smmc_pkg::SMMC_ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= smmc_pkg::SMMC_ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Request capture
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req_ff <= '0;
        end else if (st_ff == smmc_pkg::SMMC_ST_IDLE && mem_req) begin
            req_ff <= '{addr: mem_addr, wr: mem_wr};
        end
    end

    // ------------------------------------------------------------
    // Open page tracking per bank
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            open_vld_ff <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                open_pg_ff[i] <= 14'h0000;
            end
        end else if (st_ff == smmc_pkg::SMMC_ST_DEC && dec_dram) begin
            open_vld_ff[dec_bank] <= 1'b1;
            open_pg_ff[dec_bank]  <= dec_pg;
        end
    end

    // ------------------------------------------------------------
    // Cycle outputs, loaded at decode; bank select and page hit dropped after completion
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cyc_ff   <= 2'h1;
            phys_ff  <= 24'h000000;
            bank_ff  <= 2'h0;
            hit_ff   <= 1'b0;
            sbank_ff <= smmc_pkg::SRAM_NONE;
        end else if (st_ff == smmc_pkg::SMMC_ST_DEC) begin
            cyc_ff   <= dec.cyc;
            phys_ff  <= dec.phys;
            bank_ff  <= dec_bank;
            hit_ff   <= dec_dram && dec_hit;
            sbank_ff <= dec.sram_bank;
        end else if (st_ff == smmc_pkg::SMMC_ST_DONE) begin
            sbank_ff <= smmc_pkg::SRAM_NONE;
            hit_ff   <= 1'b0;
        end
    end

    // Strobe and qualifier flags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strobe_ff <= 1'b0;
            exp_ff    <= 1'b0;
            rom_ff    <= 1'b0;
            sram_ff   <= 1'b0;
            wen_ff    <= 1'b0;
        end else if (st_ff == smmc_pkg::SMMC_ST_DEC) begin
            strobe_ff <= dec_dram;
            exp_ff    <= dec.cyc == smmc_pkg::SMMC_CYC_EXP;
            rom_ff    <= dec.cyc == smmc_pkg::SMMC_CYC_ROM;
            sram_ff   <= dec.cyc == smmc_pkg::SMMC_CYC_SRAM;
            wen_ff    <= req_ff.wr && !dec.discard;
        end else if (st_ff == smmc_pkg::SMMC_ST_DONE) begin
            strobe_ff <= 1'b0;
            exp_ff    <= 1'b0;
            rom_ff    <= 1'b0;
            sram_ff   <= 1'b0;
            wen_ff    <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Output assignments
    // ------------------------------------------------------------
    assign io_rdata         = rdata_ff;
    assign mem_ack          = st_ff == smmc_pkg::SMMC_ST_DONE;
    assign cyc_kind         = cyc_ff;
    assign phys_addr        = phys_ff;
    assign dram_strobe      = strobe_ff;
    assign dram_bank        = bank_ff;
    assign page_hit         = hit_ff;
    assign exp_cycle        = exp_ff;
    assign rom_read         = rom_ff;
    assign sram_cycle       = sram_ff;
    assign mem_write_en     = wen_ff;
    assign sram_bank_select = sbank_ff;
    assign dram_mode        = dram_mode_ff;

endmodule // smmc_top
